// file: rtl/sss_regs.svh
/*
  constants for the stored-setup sweep sequencer: sizes, encodings and setup word layout.
  assumes inclusion by bare name from the sequencer and its package users.
*/
`ifndef SSS_REGS_SVH
`define SSS_REGS_SVH

// ----------------------------------------------------------------
// memory and sweep sizes
// ----------------------------------------------------------------
`define SSS_NUM_LOCS        100
`define SSS_FIRST_LOC       7'h01
`define SSS_LAST_LOC        7'h64
`define SSS_BUF_DEPTH       2500
`define SSS_LIST_DEPTH      100

// ----------------------------------------------------------------
// sweep types
// ----------------------------------------------------------------
`define SSS_TYPE_LIN        2'h0
`define SSS_TYPE_LOG        2'h1
`define SSS_TYPE_LIST       2'h2
`define SSS_TYPE_MEM        2'h3

// ----------------------------------------------------------------
// range policies
// ----------------------------------------------------------------
`define SSS_RNG_COVER       2'h0
`define SSS_RNG_AUTO        2'h1
`define SSS_RNG_HOLD        2'h2

// ----------------------------------------------------------------
// compliance-abort modes
// ----------------------------------------------------------------
`define SSS_ABT_NEVER       2'h0
`define SSS_ABT_EARLY       2'h1
`define SSS_ABT_LATE        2'h2

// ----------------------------------------------------------------
// setup word layout (fields of one stored location)
// ----------------------------------------------------------------
`define SSS_SET_W           64
`define SSS_BR_POS          0
`define SSS_RNG_POS         7
`define SSS_DLY_POS         10
`define SSS_LIM_POS         26
`define SSS_LIM_EN_POS      26

`endif

// file: rtl/sss_pkg.sv
/*
  types for the stored-setup sweep sequencer.
  assumes sss_regs.svh supplies the numeric constants.
*/
package sss_pkg;
  // sequencer states
  typedef enum logic [2:0] {
    SSS_IDLE   = 3'b000,
    SSS_SETUP  = 3'b001,
    SSS_TDLY   = 3'b010,
    SSS_CYCLE  = 3'b011,
    SSS_NEXT   = 3'b100
  } sss_state_t;
endpackage : sss_pkg

// file: rtl/sss_seq.sv
/*
  stored-setup sweep sequencer: steps linear, log, list and stored-setup
  sweeps, recalls setups, branches on limit results, counts repeats, picks
  source ranges and aborts on compliance.
  assumes the source-delay-measure cycle is an engine on the same clock that
  takes a start pulse and answers with a done pulse plus limit and
  compliance flags; levels are unsigned codes, ranges small indices.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sss_regs.svh"

// Contract
// - hold one hundred setups, recall each point
// - each location keeps full setup and branch
// - start at programmed location, cover points
// - past location 100 wrap to 1
// - branch only in memory sweep with limits
// - pass with target jumps to target
// - fail with target goes next location
// - no target: always next location
// - branches never change the point counter
// - list holds levels, fill writes range
// - repeat count capped at 2500 over points
// - counted repeats store every reading
// - endless repeats until stop, no storing
// - range policy ignored in memory sweep
// - covering range chosen once for sweep
// - per point most sensitive fitting range
// - hold range, clamp level to maximum
// - compliance abort never, early or late
// - trigger delay before every measure cycle
module sss_seq #(
  parameter int LVL_W  = 16,   // source level code width
  parameter int DLY_W  = 16,   // trigger delay count width
  parameter int NRANGE = 4     // number of source ranges
) (
  input  wire logic                ref_clk_i,
  input  wire logic                sys_rst_i,
  // configuration
  input  wire logic [1:0]          sweep_type_i,
  input  wire logic [1:0]          range_policy_i,
  input  wire logic [1:0]          abort_mode_i,
  input  wire logic                endless_i,
  input  wire logic [11:0]         repeat_cnt_i,
  input  wire logic [11:0]         num_points_i,
  input  wire logic [6:0]          start_loc_i,
  input  wire logic [LVL_W-1:0]    lvl_start_i,
  input  wire logic [LVL_W-1:0]    lvl_stop_i,
  input  wire logic [LVL_W-1:0]    lvl_step_i,
  input  wire logic [DLY_W-1:0]    trig_delay_i,
  input  wire logic [1:0]          present_range_i,
  input  wire logic [LVL_W*NRANGE-1:0] range_max_i,
  // setup store write port
  input  wire logic                setup_wr_i,
  input  wire logic [6:0]          setup_loc_i,
  input  wire logic [`SSS_SET_W-1:0] setup_data_i,
  // list fill port
  input  wire logic                fill_i,
  input  wire logic [6:0]          fill_first_i,
  input  wire logic [6:0]          fill_last_i,
  input  wire logic [LVL_W-1:0]    fill_value_i,
  input  wire logic                log_step_i,
  // control
  input  wire logic                run_i,
  input  wire logic                stop_i,
  // measure-cycle engine
  input  wire logic                cycle_done_i,
  input  wire logic                limit_pass_i,
  input  wire logic                compl_start_i,
  input  wire logic                compl_end_i,
  output logic                     cycle_start_o,
  output logic [LVL_W-1:0]         level_o,
  output logic [1:0]               range_o,
  output logic [`SSS_SET_W-1:0]    setup_o,
  output logic                     store_o,
  output logic                     busy_o,
  output logic                     aborted_o,
  output logic [6:0]               loc_o
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (NRANGE < 1 || NRANGE > 4) begin : g_chk
    $error("NRANGE must be 1..4");
  end

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [`SSS_SET_W-1:0] setup_mem [1:`SSS_NUM_LOCS]; // saved setups
  logic [LVL_W-1:0]      list_mem  [0:`SSS_LIST_DEPTH-1]; // list levels

  sss_pkg::sss_state_t st_q;        // sequencer state
  logic [11:0]         pts_left_q;  // points still to run this pass
  logic [11:0]         reps_left_q; // passes still to run
  logic [11:0]         idx_q;       // list / point index
  logic [6:0]          loc_q;       // memory location pointer
  logic [LVL_W-1:0]    lvl_q;       // current level
  logic [DLY_W-1:0]    dly_q;       // trigger delay counter
  logic [1:0]          fix_rng_q;   // range fixed for the sweep
  logic [6:0]          fill_ptr_q;  // fill walking pointer
  logic                fill_act_q;  // fill in progress
  logic                pass_lat_q;  // limit result of finished cycle

  // next location, wrapping past the last one back to the first
  function automatic logic [6:0] next_loc(input logic [6:0] l);
    next_loc = (l >= `SSS_LAST_LOC) ? `SSS_FIRST_LOC : 7'(l + 7'h01);
  endfunction : next_loc

  // most sensitive range whose maximum holds the level
  function automatic logic [1:0] fit_range(input logic [LVL_W-1:0] v,
                                           input logic [LVL_W*NRANGE-1:0] mx);
    fit_range = 2'(NRANGE - 1);
    for (int r = NRANGE - 1; r >= 0; r--) begin
      if (v <= mx[r*LVL_W +: LVL_W]) begin
        fit_range = 2'(r);
      end
    end
  endfunction : fit_range

  // repeat ceiling: buffer depth over points, zero points treated as one
  logic [11:0] rep_cap;
  logic [11:0] rep_eff;
  logic [LVL_W-1:0] hold_max;
  logic [LVL_W-1:0] big_lvl;
  logic        is_mem;
  logic        abort_now;
  logic [`SSS_SET_W-1:0] cur_setup;
  logic [6:0]  br_tgt;

  assign rep_cap  = 12'(`SSS_BUF_DEPTH / ((num_points_i == 12'h000) ? 1 : num_points_i));
  assign rep_eff  = (repeat_cnt_i > rep_cap) ? rep_cap : repeat_cnt_i;
  assign is_mem   = (sweep_type_i == `SSS_TYPE_MEM);
  assign cur_setup = setup_mem[loc_q];
  assign br_tgt   = cur_setup[`SSS_BR_POS +: 7];
  assign hold_max = range_max_i[fix_rng_q*LVL_W +: LVL_W];
  assign big_lvl  = (lvl_start_i > lvl_stop_i) ? lvl_start_i : lvl_stop_i;
  assign abort_now = cycle_done_i &&
                     (((abort_mode_i == `SSS_ABT_EARLY) && compl_start_i) ||
                      ((abort_mode_i == `SSS_ABT_LATE)  && compl_end_i));

  // ----------------------------------------------------------------
  // setup store writes
  // ----------------------------------------------------------------
  // hundred setups stored
  always_ff @(posedge ref_clk_i) begin
    if (setup_wr_i && setup_loc_i >= `SSS_FIRST_LOC && setup_loc_i <= `SSS_LAST_LOC) begin
      setup_mem[setup_loc_i] <= setup_data_i;
    end
  end

  // ----------------------------------------------------------------
  // list fill: one value into first..last, one point per clock
  // ----------------------------------------------------------------
  // fill consecutive range
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      fill_act_q <= 1'b0;
      fill_ptr_q <= 7'h00;
    end else if (fill_i && !fill_act_q) begin
      fill_act_q <= (fill_first_i <= fill_last_i);
      fill_ptr_q <= fill_first_i;
    end else if (fill_act_q) begin
      fill_act_q <= (fill_ptr_q < fill_last_i);
      fill_ptr_q <= 7'(fill_ptr_q + 7'h01);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (fill_act_q && fill_ptr_q < 7'(`SSS_LIST_DEPTH)) begin
      list_mem[fill_ptr_q] <= fill_value_i;
    end
  end

  // ----------------------------------------------------------------
  // sequencer state machine
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      st_q        <= sss_pkg::SSS_IDLE;
      pts_left_q  <= 12'h000;
      reps_left_q <= 12'h000;
      idx_q       <= 12'h000;
      loc_q       <= `SSS_FIRST_LOC;
      lvl_q       <= '0;
      dly_q       <= '0;
      fix_rng_q   <= 2'h0;
      pass_lat_q  <= 1'b0;
      aborted_o   <= 1'b0;
    end else begin
      case (st_q)
        sss_pkg::SSS_IDLE: begin
          if (run_i && num_points_i != 12'h000) begin
            st_q        <= sss_pkg::SSS_SETUP;
            pts_left_q  <= num_points_i;
            reps_left_q <= (rep_eff == 12'h000) ? 12'h001 : rep_eff;
            idx_q       <= 12'h000;
            loc_q       <= (start_loc_i >= `SSS_FIRST_LOC && start_loc_i <= `SSS_LAST_LOC)
                           ? start_loc_i : `SSS_FIRST_LOC;
            lvl_q       <= lvl_start_i;
            aborted_o   <= 1'b0;
            fix_rng_q   <= (range_policy_i == `SSS_RNG_HOLD) ? present_range_i
                           : fit_range(big_lvl, range_max_i);
          end
        end
        sss_pkg::SSS_SETUP: begin
          dly_q <= trig_delay_i;
          st_q  <= sss_pkg::SSS_TDLY;
        end
        sss_pkg::SSS_TDLY: begin
          if (dly_q == '0) begin
            st_q <= sss_pkg::SSS_CYCLE;
          end else begin
            dly_q <= dly_q - 1'b1;
          end
        end
        sss_pkg::SSS_CYCLE: begin
          if (stop_i) begin
            st_q <= sss_pkg::SSS_IDLE;
          end else if (abort_now) begin
            st_q      <= sss_pkg::SSS_IDLE;
            aborted_o <= 1'b1;
          end else if (cycle_done_i) begin
            pass_lat_q <= limit_pass_i;
            st_q       <= sss_pkg::SSS_NEXT;
          end
        end
        sss_pkg::SSS_NEXT: begin
          pts_left_q <= pts_left_q - 12'h001;
          idx_q      <= idx_q + 12'h001;
          // branch only in memory sweep with limits
          if (is_mem && cur_setup[`SSS_LIM_EN_POS] && pass_lat_q &&
              br_tgt >= `SSS_FIRST_LOC && br_tgt <= `SSS_LAST_LOC) begin
            loc_q <= br_tgt;
          end else begin
            loc_q <= next_loc(loc_q);
          end
          // level step for linear or log, list index otherwise
          if (sweep_type_i == `SSS_TYPE_LIN) begin
            lvl_q <= LVL_W'(lvl_q + lvl_step_i);
          end else if (sweep_type_i == `SSS_TYPE_LOG) begin
            lvl_q <= log_step_i ? LVL_W'(lvl_q + lvl_step_i) : lvl_q;
          end
          if (stop_i) begin
            st_q <= sss_pkg::SSS_IDLE;
          end else if (pts_left_q > 12'h001) begin
            st_q <= sss_pkg::SSS_SETUP;
          end else if (endless_i || reps_left_q > 12'h001) begin
            reps_left_q <= endless_i ? reps_left_q : reps_left_q - 12'h001;
            pts_left_q  <= num_points_i;
            idx_q       <= 12'h000;
            loc_q       <= (start_loc_i >= `SSS_FIRST_LOC && start_loc_i <= `SSS_LAST_LOC)
                           ? start_loc_i : `SSS_FIRST_LOC;
            lvl_q       <= lvl_start_i;
            st_q        <= sss_pkg::SSS_SETUP;
          end else begin
            st_q <= sss_pkg::SSS_IDLE;
          end
        end
        default: st_q <= sss_pkg::SSS_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // point level and range outputs, registered at setup
  // ----------------------------------------------------------------
  logic [LVL_W-1:0] pt_lvl;
  assign pt_lvl = (sweep_type_i == `SSS_TYPE_LIST && idx_q < 12'(`SSS_LIST_DEPTH))
                  ? list_mem[idx_q[6:0]] : lvl_q;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      level_o <= '0;
      range_o <= 2'h0;
      setup_o <= '0;
      loc_o   <= `SSS_FIRST_LOC;
    end else if (st_q == sss_pkg::SSS_SETUP) begin
      loc_o <= loc_q;
      if (is_mem) begin
        setup_o <= cur_setup;
        range_o <= cur_setup[`SSS_RNG_POS +: 2];
        level_o <= pt_lvl;
      end else if (range_policy_i == `SSS_RNG_AUTO) begin
        range_o <= fit_range(pt_lvl, range_max_i);
        level_o <= pt_lvl;
      end else if (range_policy_i == `SSS_RNG_HOLD) begin
        range_o <= fix_rng_q;
        level_o <= (pt_lvl > hold_max) ? hold_max : pt_lvl;
      end else begin
        range_o <= fix_rng_q;
        level_o <= pt_lvl;
      end
    end
  end

  // ----------------------------------------------------------------
  // handshake outputs
  // ----------------------------------------------------------------
  assign cycle_start_o = (st_q == sss_pkg::SSS_TDLY) && (dly_q == '0);
  assign busy_o        = (st_q != sss_pkg::SSS_IDLE);
  assign store_o       = (st_q == sss_pkg::SSS_CYCLE) && cycle_done_i && !endless_i;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_wrap_loc: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    loc_q >= `SSS_FIRST_LOC && loc_q <= `SSS_LAST_LOC)
    else $error("location pointer out of range");
  a_start_after_dly: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    st_q == sss_pkg::SSS_SETUP |=> st_q == sss_pkg::SSS_TDLY && dly_q == trig_delay_i)
    else $error("delay not loaded before cycle");
  a_wait_done: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    st_q == sss_pkg::SSS_CYCLE && !cycle_done_i && !stop_i |=> st_q == sss_pkg::SSS_CYCLE)
    else $error("left cycle before done");
  a_pts_count: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    st_q == sss_pkg::SSS_NEXT && pts_left_q > 12'h001 && !stop_i
      |=> pts_left_q == $past(pts_left_q) - 12'h001)
    else $error("point counter wrong");
  a_no_store_endless: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    endless_i |-> !store_o)
    else $error("stored in endless mode");
  a_store_counted: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    st_q == sss_pkg::SSS_CYCLE && cycle_done_i && !endless_i |-> store_o)
    else $error("reading not stored");
  a_branch_pass: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    st_q == sss_pkg::SSS_NEXT && is_mem && cur_setup[`SSS_LIM_EN_POS] && pass_lat_q &&
    br_tgt >= `SSS_FIRST_LOC && br_tgt <= `SSS_LAST_LOC && pts_left_q > 12'h001 && !stop_i
      |=> loc_q == $past(br_tgt))
    else $error("pass branch not taken");
  a_seq_fail: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    st_q == sss_pkg::SSS_NEXT && !pass_lat_q && pts_left_q > 12'h001 && !stop_i
      |=> loc_q == next_loc($past(loc_q)))
    else $error("fail did not go next");
  a_abort_late: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    st_q == sss_pkg::SSS_CYCLE && abort_now && !stop_i |=> aborted_o && !busy_o)
    else $error("compliance abort missed");

  c_wrap: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    loc_q == `SSS_LAST_LOC && st_q == sss_pkg::SSS_NEXT ##1 loc_q == `SSS_FIRST_LOC);
  c_branch: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    st_q == sss_pkg::SSS_NEXT && is_mem && pass_lat_q);
  c_abort: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i) abort_now);

endmodule : sss_seq
`default_nettype wire

// file: bench/sss_eng_model.sv
/*
  behavioural source-delay-measure engine facing the sequencer.
  assumes the sequencer starts one cycle at a time on ref_clk_i and that
  the bench sets latency and result flags before each run.
*/
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// measure engine model
// ----------------------------------------
module sss_eng_model (
  input  wire logic ref_clk_i,
  input  wire logic cycle_start_i,
  input  wire logic [31:0] lat_i,
  input  wire logic pass_i,
  input  wire logic cs_i,
  input  wire logic ce_i,
  output logic      done_o,
  output logic      pass_o,
  output logic      cs_o,
  output logic      ce_o
);
  int cnt = 0; // cycles left until done
  // load latency on a start, count down otherwise
  always @(posedge ref_clk_i) begin
    if (cycle_start_i === 1'b1) cnt <= lat_i;
    else if (cnt > 0) cnt <= cnt - 1;
  end
  // flags toggle outside done so a stale value is never trusted
  initial {done_o, pass_o, cs_o, ce_o} = 4'h0;
  always @(negedge ref_clk_i) begin
    done_o = (cnt == 1);
    pass_o = done_o ? pass_i : ~pass_o;
    cs_o   = done_o ? cs_i : ~cs_o;
    ce_o   = done_o ? ce_i : ~ce_o;
  end
endmodule : sss_eng_model
`default_nettype wire

// file: bench/test_stored_setup_sweep_sequencer.sv
/*
  self-checking bench for the sweep sequencer with an engine model.
  assumes the setup word layout and encodings of sss_regs.svh.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sss_regs.svh"
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin err_count++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
module test_stored_setup_sweep_sequencer;
  // ----------------------------------------
  // stimulus and observation
  // ----------------------------------------
  logic ref_clk_i = 0, sys_rst_i = 1, endless_i = 0, setup_wr_i = 0;
  logic run_i = 0, stop_i = 0, done, pass, cs, ce, pass_c = 0, cs_c = 0, ce_c = 0;
  logic [1:0] sweep_type_i = 0, range_policy_i = 0, abort_mode_i = 0, present_range_i = 0;
  logic [11:0] repeat_cnt_i = 1, num_points_i = 1;
  logic [6:0] start_loc_i = 1, setup_loc_i = 1, loc_o;
  logic [15:0] lvl_start_i = 0, lvl_stop_i = 0, lvl_step_i = 0, trig_delay_i = 0, level_o;
  logic [63:0] setup_data_i = 0, setup_o, range_max_i = 64'hffff_1000_0100_0010;
  logic [1:0] range_o;
  logic fill_i = 0, log_step_i = 0;
  logic [6:0] fill_first_i = 0, fill_last_i = 0;
  logic [15:0] fill_value_i = 0;
  logic cycle_start_o, store_o, busy_o, aborted_o;
  int err_count = 0, checked = 0, cyc = 0, nst = 0, nsto = 0, rcyc, lat = 1;
  logic [6:0] locq[$];
  logic [15:0] lvlq[$];
  logic [1:0] rngq[$];
  int tq[$];
  logic [63:0] setq[$];
  always #4 ref_clk_i = ~ref_clk_i; // 125 MHz
  sss_seq dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .sweep_type_i(sweep_type_i),
    .range_policy_i(range_policy_i), .abort_mode_i(abort_mode_i), .endless_i(endless_i),
    .repeat_cnt_i(repeat_cnt_i), .num_points_i(num_points_i), .start_loc_i(start_loc_i),
    .lvl_start_i(lvl_start_i), .lvl_stop_i(lvl_stop_i), .lvl_step_i(lvl_step_i),
    .trig_delay_i(trig_delay_i), .present_range_i(present_range_i), .range_max_i(range_max_i),
    .setup_wr_i(setup_wr_i), .setup_loc_i(setup_loc_i), .setup_data_i(setup_data_i),
    .fill_i(fill_i), .fill_first_i(fill_first_i), .fill_last_i(fill_last_i),
    .fill_value_i(fill_value_i), .log_step_i(log_step_i), .run_i(run_i), .stop_i(stop_i),
    .cycle_done_i(done),
    .limit_pass_i(pass), .compl_start_i(cs), .compl_end_i(ce), .cycle_start_o(cycle_start_o),
    .level_o(level_o), .range_o(range_o), .setup_o(setup_o), .store_o(store_o),
    .busy_o(busy_o), .aborted_o(aborted_o), .loc_o(loc_o));
  sss_eng_model eng (.ref_clk_i(ref_clk_i), .cycle_start_i(cycle_start_o), .lat_i(lat),
    .pass_i(pass_c), .cs_i(cs_c), .ce_i(ce_c), .done_o(done), .pass_o(pass), .cs_o(cs),
    .ce_o(ce));
  // record what each point presents to the engine
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (store_o === 1'b1) nsto <= nsto + 1;
    if (cycle_start_o === 1'b1) begin
      nst <= nst + 1;
      locq.push_back(loc_o); lvlq.push_back(level_o); rngq.push_back(range_o);
      setq.push_back(setup_o); tq.push_back(cyc);
    end
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic wr_setup(input logic [6:0] l, input logic [63:0] d);
    @(negedge ref_clk_i); setup_wr_i = 1; setup_loc_i = l; setup_data_i = d;
    @(negedge ref_clk_i); setup_wr_i = 0;
  endtask : wr_setup
  task automatic go(input logic [11:0] n);
    int k;
    locq = {}; lvlq = {}; rngq = {}; setq = {}; tq = {}; nst = 0; nsto = 0;
    @(negedge ref_clk_i); num_points_i = n; run_i = 1; rcyc = cyc;
    @(negedge ref_clk_i); run_i = 0;
    for (k = 0; k < 30000 && busy_o !== 1'b0; k++) @(negedge ref_clk_i);
    // a sweep that never ends is a mismatch and closes the run
    if (busy_o !== 1'b0) begin
      err_count++;
      print_verdict;
    end
  endtask : go
  // memory sweep from 98, wraps, recalls setups, ignores range policy
  task automatic t_wrap;
    logic [6:0] ex[6] = '{7'h62, 7'h63, 7'h64, 7'h01, 7'h02, 7'h03};
    sweep_type_i = `SSS_TYPE_MEM; range_policy_i = `SSS_RNG_HOLD; start_loc_i = 7'h62;
    wr_setup(7'h62, 64'h5a5a_0000_0000_0100); // range field 2
    go(12'h006);
    `CHK("points", 6, nst)
    `CHK("stores", 6, nsto)
    for (int i = 0; i < 6; i++) `CHK("loc", ex[i], locq[i])
    `CHK("setup", 64'h5a5a_0000_0000_0100, setq[0])
    `CHK("range", 2'h2, rngq[0])
    $display("test wrap done");
  endtask : t_wrap
  // branch at location 3 to 7 on pass, next on fail
  task automatic t_branch;
    logic [6:0] ep[6] = '{7'h01, 7'h02, 7'h03, 7'h07, 7'h08, 7'h09};
    start_loc_i = 7'h01; // fail target never configured
    wr_setup(7'h03, 64'h0000_0000_0400_0007);
    pass_c = 1; go(12'h006);
    `CHK("br points", 6, nst)
    for (int i = 0; i < 6; i++) `CHK("pass loc", ep[i], locq[i])
    pass_c = 0; go(12'h005);
    `CHK("fail loc", 7'h04, locq[3])
    // limits on but no target: next location even on pass
    wr_setup(7'h03, 64'h0000_0000_0400_0000); pass_c = 1; go(12'h005);
    `CHK("next loc", 7'h04, locq[3])
    // target set but no limit tests: no branch
    wr_setup(7'h03, 64'h0000_0000_0000_0007); go(12'h005);
    `CHK("no limits", 7'h04, locq[3])
    // branch fully armed, but not a memory sweep
    wr_setup(7'h03, 64'h0000_0000_0400_0007);
    sweep_type_i = `SSS_TYPE_LIN; go(12'h004);
    `CHK("no mem br", 7'h04, locq[3])
    pass_c = 0;
    $display("test branch done");
  endtask : t_branch
  // linear sweep, trigger delay, hold policy clamps to range maximum
  task automatic t_lin;
    sweep_type_i = `SSS_TYPE_LIN; lvl_start_i = 16'h0008; lvl_stop_i = 16'h0018;
    lvl_step_i = 16'h0008; trig_delay_i = 16'h0003; lat = 3; go(12'h003);
    `CHK("delay", rcyc + 5, tq[0])
    `CHK("gap", tq[0] + 6 + 3, tq[1])
    `CHK("lvl0", 16'h0008, lvlq[0])
    `CHK("lvl2", 16'h0010, lvlq[2])
    `CHK("hold rng", 2'h0, rngq[2])
    range_policy_i = `SSS_RNG_AUTO; lvl_step_i = 16'h0100; go(12'h003);
    `CHK("auto rng", 2'h2, rngq[1])
    // stop level 0208 is the top of the sweep, so range 2 covers it all
    range_policy_i = `SSS_RNG_COVER; lvl_stop_i = 16'h0208; go(12'h003);
    `CHK("cover rng", 2'h2, rngq[0])
    trig_delay_i = 0; lat = 1;
    $display("test linear done");
  endtask : t_lin
  // list fill and list sweep, then a host-stepped log sweep
  task automatic t_list;
    logic [15:0] el[5] = '{16'h0050, 16'h0050, 16'h0300, 16'h0300, 16'h0050};
    @(negedge ref_clk_i); fill_first_i = 7'h00; fill_last_i = 7'h04;
    fill_value_i = 16'h0050; fill_i = 1;
    @(negedge ref_clk_i); fill_i = 0;
    repeat (8) @(negedge ref_clk_i); fill_first_i = 7'h02; fill_last_i = 7'h03;
    fill_value_i = 16'h0300; fill_i = 1;
    @(negedge ref_clk_i); fill_i = 0;
    repeat (8) @(negedge ref_clk_i);
    sweep_type_i = `SSS_TYPE_LIST; range_policy_i = `SSS_RNG_AUTO; go(12'h005);
    for (int i = 0; i < 5; i++) `CHK("list lvl", el[i], lvlq[i])
    `CHK("list rng", 2'h2, rngq[3])
    // start, stop and points supplied, host gives the step
    sweep_type_i = `SSS_TYPE_LOG; lvl_start_i = 16'h0010; lvl_stop_i = 16'h0050;
    lvl_step_i = 16'h0020; log_step_i = 1; go(12'h003);
    `CHK("log lvl", 16'h0050, lvlq[2])
    `CHK("log rng", 2'h1, rngq[2])
    sweep_type_i = `SSS_TYPE_LIN; log_step_i = 0;
    $display("test list done");
  endtask : t_list
  // every abort mode against early and late compliance
  task automatic t_abort;
    logic [3:0] tb[6] = '{4'h2, 4'h1, 4'h6, 4'h5, 4'ha, 4'h9};
    for (int i = 0; i < 6; i++) begin
      abort_mode_i = tb[i][3:2]; cs_c = ~tb[i][0]; ce_c = tb[i][0]; go(12'h004);
      `CHK("abort", tb[i] == 4'h6 || tb[i] == 4'h9, aborted_o)
      `CHK("ab pts", (tb[i] == 4'h6 || tb[i] == 4'h9) ? 1 : 4, nst)
    end
    cs_c = 0; ce_c = 0; abort_mode_i = 0;
    $display("test abort done");
  endtask : t_abort
  // capped counted repeats and endless repeats without storing
  task automatic t_repeat;
    lvl_step_i = 16'h0001; repeat_cnt_i = 12'h005; go(12'h4b0);
    `CHK("cap pts", 2400, nst)
    `CHK("cap sto", 2400, nsto)
    repeat_cnt_i = 1; endless_i = 1; fork go(12'h002); join_none
    repeat (60) @(negedge ref_clk_i);
    `CHK("endless", 1'b1, busy_o)
    stop_i = 1; repeat (20) @(negedge ref_clk_i); stop_i = 0; endless_i = 0;
    `CHK("stopped", 1'b0, busy_o)
    `CHK("no store", 0, nsto)
    $display("test repeat done");
  endtask : t_repeat
  // ----------------------------------------
  // verdict and sequence
  // ----------------------------------------
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (3) @(negedge ref_clk_i);
    sys_rst_i = 0;
    t_wrap; t_branch; t_lin; t_list; t_abort; t_repeat;
    print_verdict;
  end
  // sweeps total well under 40000 cycles
  initial begin
    #400000;
    err_count++;
    print_verdict;
  end
endmodule : test_stored_setup_sweep_sequencer
`default_nettype wire
